/* common/upper_port_consts.vh */
// constants for the upper port pin function mux and its register file
// ============================================================
`ifndef UPPER_PORT_CONSTS_VH
`define UPPER_PORT_CONSTS_VH

// ============================================================
// register byte offsets on the apb bus
`define UP_OFF_PIN_LEVELS    8'h00
`define UP_OFF_LATCH         8'h04
`define UP_OFF_DIRECTION     8'h08
`define UP_OFF_SHARED        8'h0C
`define UP_OFF_WATCHDOG      8'h10
`define UP_OFF_MUX_CFG       8'h14

// ============================================================
// reset values
`define UP_RST_LATCH         8'h00
`define UP_RST_DIRECTION     8'hFF
`define UP_RST_ANALOG_SEL    8'h00
`define UP_RST_SHARED_DFLT   8'h00
`define UP_RST_MUX_CFG       2'h3

// ============================================================
// implemented bits of the analog select register
`define UP_ANALOG_SEL_MASK   8'hFC

// ============================================================
// field positions
`define UP_WDT_SHARED_BIT    4
`define UP_CFG_PPORT_BIT     0
`define UP_CFG_PWM_BIT       1
`define UP_PIN_FIRST_MUXED   5

`endif

/* core/port_reg8.v */
// eight-bit software register with reset value and implemented-bit mask
`timescale 1ns/1ps
`default_nettype none

module port_reg8
#(
    parameter [7:0] RESET_VALUE = 8'h00,  // value after reset
    parameter [7:0] IMPL_MASK   = 8'hFF   // bits that exist
)
(
    input  wire       i_clock,
    input  wire       i_resetn,
    input  wire       i_write,
    input  wire [7:0] i_data,
    output wire [7:0] o_value
);

    // ============================================================
    // storage
    reg [7:0] value_q;   // held register contents

    // missing bits never store, so they read as zero
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            value_q <= RESET_VALUE & IMPL_MASK;
        end
        else if (i_write)
        begin
            value_q <= i_data & IMPL_MASK;
        end
    end

    assign o_value = value_q;

endmodule

`default_nettype wire

/* core/upper_pin_cell.v */
// function mux for one shared pin: pwm, parallel port, plain port bit
`timescale 1ns/1ps
`default_nettype none

module upper_pin_cell
(
    input  wire i_latch,      // port latch bit
    input  wire i_dir,        // direction bit, 1 = input
    input  wire i_pport_en,   // parallel port owns the pin
    input  wire i_pport_out,  // parallel port level
    input  wire i_pport_oe,   // parallel port drives the pin
    input  wire i_pwm_en,     // pwm channel mapped onto the pin
    input  wire i_pwm_out,    // pwm channel level
    input  wire i_pwm_hiz,    // pwm shutdown asks for high impedance
    output reg  o_out,        // level driven onto the pin
    output reg  o_oe          // pin driver enable
);

    // ============================================================
    // priority: pwm first, then parallel port, then latch
    always @*
    begin
        o_out = i_latch;
        o_oe  = ~i_dir;
        if (i_pwm_en)
        begin
            // pwm output uses the direction bit as its enable
            o_out = i_pwm_out;
            o_oe  = ~i_dir & ~i_pwm_hiz;
        end
        else if (i_pport_en)
        begin
            // direction bit is overridden here
            o_out = i_pport_out;
            o_oe  = i_pport_oe;
        end
    end

endmodule

`default_nettype wire

/* core/upper_port_pin_function_mux.v */
// upper port pin function mux with apb register file
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "upper_port_consts.vh"

module upper_port_pin_function_mux
#(
    // set to 1 for the small package, which lacks this port
    parameter SMALL_PACKAGE = 0
)
(
    input  wire        i_clock,
    input  wire        i_resetn,
    // apb slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    // port pins
    input  wire [7:0]  i_pin_in,
    output wire [7:0]  o_pin_out,
    output wire [7:0]  o_pin_oe,
    // parallel port unit
    input  wire        i_pport_active,
    input  wire        i_pport_slave_mode,
    input  wire        i_pport_byte_enable,
    input  wire        i_pport_read_strobe,
    input  wire        i_pport_write_strobe,
    output wire        o_pport_read_in,
    output wire        o_pport_write_in,
    // enhanced pwm units
    input  wire        i_pwm3_channel_b,
    input  wire        i_pwm1_channel_c,
    input  wire        i_pwm1_channel_b,
    input  wire [2:0]  i_pwm_chan_en,
    input  wire        i_pwm3_shutdown_hiz,
    input  wire        i_pwm1_shutdown_hiz,
    output wire        o_pwm_on_default_pins,
    // analog and comparator taps
    output wire        o_analog_input_13,
    output wire        o_analog_input_14,
    output wire        o_analog_input_15,
    output wire        o_comparator2_input_d,
    output wire        o_comparator1_input_c
);

    // ============================================================
    // address decode helper
    // ============================================================

    // true when the bus address selects the given word offset
    function addr_hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            addr_hit = (addr[7:2] == off[7:2]);
        end
    endfunction

    // ============================================================
    // apb handshake
    // ============================================================

    wire       setup_phase;   // first cycle of a transfer
    wire       access_phase;  // second cycle, completes at once
    wire       bus_write;     // write takes effect this edge
    wire       hit_levels;    // pin level register selected
    wire       hit_latch;     // latch register selected
    wire       hit_dir;       // direction register selected
    wire       hit_shared;    // shared address selected
    wire       hit_wdt;       // watchdog control selected
    wire       hit_cfg;       // pin mux configuration selected
    wire       mapped;        // any register selected

    assign setup_phase  = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;
    assign bus_write    = access_phase & i_pwrite;

    assign hit_levels = addr_hit(i_paddr, `UP_OFF_PIN_LEVELS);
    assign hit_latch  = addr_hit(i_paddr, `UP_OFF_LATCH);
    assign hit_dir    = addr_hit(i_paddr, `UP_OFF_DIRECTION);
    assign hit_shared = addr_hit(i_paddr, `UP_OFF_SHARED);
    assign hit_wdt    = addr_hit(i_paddr, `UP_OFF_WATCHDOG);
    assign hit_cfg    = addr_hit(i_paddr, `UP_OFF_MUX_CFG);

    assign mapped = hit_levels | hit_latch | hit_dir
                  | hit_shared | hit_wdt | hit_cfg;

    // never wait states: every access ends in its first access cycle
    assign o_pready  = 1'b1;
    // an unmapped address completes with an error and reads zero
    assign o_pslverr = access_phase & ~mapped;

    // ============================================================
    // control registers
    // ============================================================

    reg        shared_en_q;   // watchdog control bit 4
    reg  [1:0] mux_cfg_q;     // pin mux configuration bits
    wire [7:0] latch_val;     // output latch contents
    wire [7:0] dir_val;       // direction contents
    wire [7:0] analog_val;    // analog select contents
    wire [7:0] dflt_val;      // default register at shared address
    wire       port_wr_ok;    // port registers exist
    wire       latch_wr;      // latch write strobe
    wire       dir_wr;        // direction write strobe
    wire       analog_wr;     // analog select write strobe
    wire       dflt_wr;       // default register write strobe
    wire       pport_mux_sel; // pport_pin_mux_select, 0 = here
    wire       pwm_mux_sel;   // pwm_pin_mux_select, 0 = here

    // small package has no port: latch and direction writes fall away
    assign port_wr_ok = (SMALL_PACKAGE == 0);

    // writing the level register also lands in the latch
    assign latch_wr = bus_write & port_wr_ok
                    & (hit_latch | hit_levels);
    assign dir_wr   = bus_write & port_wr_ok & hit_dir;

    // shared address steers by the watchdog control bit
    assign analog_wr = bus_write & hit_shared & shared_en_q;
    assign dflt_wr   = bus_write & hit_shared & ~shared_en_q;

    // watchdog control: only the shared-access bit lives here
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            shared_en_q <= 1'b0;
        end
        else if (bus_write & hit_wdt)
        begin
            shared_en_q <= i_pwdata[`UP_WDT_SHARED_BIT];
        end
    end

    // configuration bits come up erased, alternate pins unused
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mux_cfg_q <= `UP_RST_MUX_CFG;
        end
        else if (bus_write & hit_cfg)
        begin
            mux_cfg_q <= i_pwdata[1:0];
        end
    end

    assign pport_mux_sel = mux_cfg_q[`UP_CFG_PPORT_BIT];
    assign pwm_mux_sel   = mux_cfg_q[`UP_CFG_PWM_BIT];

    // output latch
    port_reg8
    #(
        .RESET_VALUE (`UP_RST_LATCH),
        .IMPL_MASK   (8'hFF)
    )
    u_latch
    (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_write  (latch_wr),
        .i_data   (i_pwdata[7:0]),
        .o_value  (latch_val)
    );

    // direction, all inputs after reset
    port_reg8
    #(
        .RESET_VALUE (`UP_RST_DIRECTION),
        .IMPL_MASK   (8'hFF)
    )
    u_dir
    (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_write  (dir_wr),
        .i_data   (i_pwdata[7:0]),
        .o_value  (dir_val)
    );

    // analog select: zero bits mean analog, so reset picks analog
    port_reg8
    #(
        .RESET_VALUE (`UP_RST_ANALOG_SEL),
        .IMPL_MASK   (`UP_ANALOG_SEL_MASK)
    )
    u_analog
    (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_write  (analog_wr),
        .i_data   (i_pwdata[7:0]),
        .o_value  (analog_val)
    );

    // default register hidden behind the same address
    port_reg8
    #(
        .RESET_VALUE (`UP_RST_SHARED_DFLT),
        .IMPL_MASK   (8'hFF)
    )
    u_dflt
    (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_write  (dflt_wr),
        .i_data   (i_pwdata[7:0]),
        .o_value  (dflt_val)
    );

    // ============================================================
    // pin function selection
    // ============================================================

    wire [7:0] pin_analog;   // pin set to analog input
    wire [7:0] pin_level;    // digital level seen by software
    wire [7:5] pp_en;        // parallel port owns pin
    wire [7:5] pp_out;       // parallel port level per pin
    wire [7:5] pp_oe;        // parallel port drive per pin
    wire [7:5] pwm_en;       // pwm channel owns pin
    wire [7:5] pwm_out;      // pwm level per pin
    wire [7:5] pwm_hiz;      // pwm shutdown tristate per pin
    wire [7:0] cell_out;     // driven levels
    wire [7:0] cell_oe;      // driver enables

    // analog bits for channels 13 to 15 sit on pins 5 to 7
    assign pin_analog = {~analog_val[7:5], 5'h00};

    // analog pins read back low; the driver is left alone
    assign pin_level = i_pin_in & ~pin_analog;

    // parallel port owns each of the three pins while it is active, its mux bit is 0 and no pwm channel takes that pin
    assign pp_en = {3{i_pport_active & ~pport_mux_sel}};
    // byte enable is an output only
    assign pp_out[5] = i_pport_byte_enable;
    assign pp_oe[5]  = 1'b1;
    // strobes turn into inputs when the port acts as slave
    assign pp_out[6] = i_pport_read_strobe;
    assign pp_oe[6]  = ~i_pport_slave_mode;
    assign pp_out[7] = i_pport_write_strobe;
    assign pp_oe[7]  = ~i_pport_slave_mode;

    // pwm channels land here only while their mux bit is clear
    assign pwm_en  = i_pwm_chan_en & {3{~pwm_mux_sel}};
    assign pwm_out = {i_pwm1_channel_b,
                      i_pwm1_channel_c,
                      i_pwm3_channel_b};
    assign pwm_hiz = {i_pwm1_shutdown_hiz,
                      i_pwm1_shutdown_hiz,
                      i_pwm3_shutdown_hiz};

    // tells the pwm units to keep their default pins
    assign o_pwm_on_default_pins = pwm_mux_sel;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_pin
            if (gi >= `UP_PIN_FIRST_MUXED)
            begin : g_muxed
                // shared pin with alternate functions
                upper_pin_cell u_cell
                (
                    .i_latch     (latch_val[gi]),
                    .i_dir       (dir_val[gi]),
                    .i_pport_en  (pp_en[gi]),
                    .i_pport_out (pp_out[gi]),
                    .i_pport_oe  (pp_oe[gi]),
                    .i_pwm_en    (pwm_en[gi]),
                    .i_pwm_out   (pwm_out[gi]),
                    .i_pwm_hiz   (pwm_hiz[gi]),
                    .o_out       (cell_out[gi]),
                    .o_oe        (cell_oe[gi])
                );
            end
            else
            begin : g_plain
                // lower pins stay plain port bits here
                assign cell_out[gi] = latch_val[gi];
                assign cell_oe[gi]  = ~dir_val[gi];
            end
        end
    endgenerate

    // the small package has no pins to drive
    assign o_pin_out = port_wr_ok ? cell_out : 8'h00;
    assign o_pin_oe  = port_wr_ok ? cell_oe  : 8'h00;

    // strobe inputs for slave use take the raw pin level
    assign o_pport_read_in  = i_pin_in[6];
    assign o_pport_write_in = i_pin_in[7];

    // analog taps: active while the pin is set to analog
    assign o_analog_input_13     = pin_analog[5];
    assign o_analog_input_14     = pin_analog[6];
    assign o_analog_input_15     = pin_analog[7];
    // comparator inputs are plain analog taps, always present
    assign o_comparator2_input_d = i_pin_in[5];
    assign o_comparator1_input_c = i_pin_in[6];

    // ============================================================
    // read path
    // ============================================================

    reg [7:0]  rd_byte;      // selected register contents
    reg [31:0] prdata_q;     // read data held for the access phase

    // pick the register named by the address
    always @*
    begin
        rd_byte = 8'h00;
        if (hit_levels)
        begin
            rd_byte = port_wr_ok ? pin_level : 8'h00;
        end
        else if (hit_latch)
        begin
            rd_byte = port_wr_ok ? latch_val : 8'h00;
        end
        else if (hit_dir)
        begin
            rd_byte = port_wr_ok ? dir_val : 8'h00;
        end
        else if (hit_shared)
        begin
            // which of the two registers answers depends on bit 4
            rd_byte = shared_en_q ? analog_val : dflt_val;
        end
        else if (hit_wdt)
        begin
            rd_byte = {3'h0, shared_en_q, 4'h0};
        end
        else if (hit_cfg)
        begin
            rd_byte = {6'h00, mux_cfg_q};
        end
        else
        begin
            // unmapped: read as zero
            rd_byte = 8'h00;
        end
    end

    // captured in the setup cycle so the access cycle reads a flop;
    // only the pin level register, which follows the pins, can change between the two edges
    always @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (setup_phase)
        begin
            prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    assign o_prdata = prdata_q;

endmodule

`default_nettype wire

/* sim/upper_port_chk.sv */
// concurrent checks on the ports of the upper port pin function mux
`timescale 1ns/1ps
`default_nettype none

module upper_port_chk
(
    input wire logic        i_clock,
    input wire logic        i_resetn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_pin_in,
    input wire logic [7:0]  o_pin_out,
    input wire logic [7:0]  o_pin_oe,
    input wire logic        o_pslverr,
    input wire logic        o_pport_read_in,
    input wire logic        o_pport_write_in,
    input wire logic        i_pwm3_channel_b,
    input wire logic [2:0]  i_pwm_chan_en,
    input wire logic        i_pwm3_shutdown_hiz,
    input wire logic        i_pwm1_shutdown_hiz,
    input wire logic        o_pwm_on_default_pins,
    input wire logic        o_analog_input_13,
    input wire logic        o_analog_input_14,
    input wire logic        o_analog_input_15,
    input wire logic        o_comparator2_input_d,
    input wire logic        o_comparator1_input_c
);
    // ============================================================
    // one clock domain, so clock and reset are given once
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    AST_ERR_ONLY_ACCESS: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("slave error outside an access phase");
    AST_RESET_STATE: assert property ($rose(i_resetn) |-> o_pin_oe == 8'h00 &&
        {o_analog_input_15, o_analog_input_14, o_analog_input_13} == 3'h7 && o_pwm_on_default_pins)
        else $error("pins not in analog input state after reset");
    AST_TAPS: assert property (o_comparator2_input_d == i_pin_in[5] &&
        o_comparator1_input_c == i_pin_in[6]) else $error("comparator tap differs from pin");
    AST_STROBE_IN: assert property (o_pport_read_in == i_pin_in[6] &&
        o_pport_write_in == i_pin_in[7]) else $error("strobe input differs from pin");
    AST_PWM5_HIZ: assert property (i_pwm_chan_en[0] && !o_pwm_on_default_pins &&
        i_pwm3_shutdown_hiz |-> !o_pin_oe[5]) else $error("pin 5 driven in shutdown");
    AST_PWM67_HIZ: assert property (i_pwm_chan_en[2:1] == 2'h3 && !o_pwm_on_default_pins &&
        i_pwm1_shutdown_hiz |-> o_pin_oe[7:6] == 2'h0) else $error("pins 7:6 driven in shutdown");
    AST_PWM5_LEVEL: assert property (i_pwm_chan_en[0] && !o_pwm_on_default_pins &&
        o_pin_oe[5] |-> o_pin_out[5] == i_pwm3_channel_b) else $error("pin 5 not the pwm level");
    // mux selects only move when software writes
    AST_MUX_BY_WRITE: assert property (!$stable(o_pwm_on_default_pins) |->
        $past(i_psel && i_penable && i_pwrite)) else $error("pwm pin mux moved without write");
    AST_ANALOG_BY_WRITE: assert property (
        !$stable({o_analog_input_15, o_analog_input_14, o_analog_input_13}) |->
        $past(i_psel && i_penable && i_pwrite)) else $error("analog select moved without write");
endmodule

bind upper_port_pin_function_mux upper_port_chk u_chk (.i_clock, .i_resetn, .i_psel, .i_penable,
    .i_pwrite, .i_pin_in, .o_pin_out, .o_pin_oe, .o_pslverr, .o_pport_read_in, .o_pport_write_in,
    .i_pwm3_channel_b, .i_pwm_chan_en, .i_pwm3_shutdown_hiz, .i_pwm1_shutdown_hiz,
    .o_pwm_on_default_pins, .o_analog_input_13, .o_analog_input_14, .o_analog_input_15,
    .o_comparator2_input_d, .o_comparator1_input_c);

`default_nettype wire

/* sim/board_pins.sv */
// board side of the port pins: resolves each pin from all drivers
`timescale 1ns/1ps
`default_nettype none

module board_pins
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_drive,
    input  wire logic [7:0] i_drive_en,
    output logic      [7:0] o_level
);
    // ============================================================
    // floating pins show a pattern that changes every cycle, so a
    // stale value is never mistaken for a real level
    logic [7:0] idle_q = 8'h55;
    always @(posedge i_clock)
    begin
        idle_q <= ~idle_q;
    end
    assign o_level = (i_oe & i_out) | (~i_oe & i_drive_en & i_drive) |
                     (~i_oe & ~i_drive_en & idle_q);
endmodule

`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the upper port pin function mux
`timescale 1ns/1ps
`default_nettype none
`include "upper_port_consts.vh"

module testbench;
    // ============================================================
    // stimulus and observed signals
    logic        i_clock = 1'h0;
    logic        i_resetn = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, rd_in, wr_in, pwm_dflt, a13, a14, a15;
    logic [7:0]  pin, pin_out, pin_oe, drv = 8'h00, drv_en = 8'h00;
    logic        pp_act = 1'h0, pp_slave = 1'h0, pp_be = 1'h0, pp_rd = 1'h0, pp_wr = 1'h0;
    logic        p3b = 1'h0, p1c = 1'h0, p1b = 1'h0, hiz3 = 1'h0, hiz1 = 1'h0;
    logic [2:0]  chan_en = 3'h0;
    int          n_fail = 0, n_tests = 0;

    always #2.5 i_clock = ~i_clock;

    upper_port_pin_function_mux u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin_in(pin),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_pport_active(pp_act),
        .i_pport_slave_mode(pp_slave), .i_pport_byte_enable(pp_be), .i_pport_read_strobe(pp_rd),
        .i_pport_write_strobe(pp_wr), .o_pport_read_in(rd_in), .o_pport_write_in(wr_in),
        .i_pwm3_channel_b(p3b), .i_pwm1_channel_c(p1c), .i_pwm1_channel_b(p1b),
        .i_pwm_chan_en(chan_en), .i_pwm3_shutdown_hiz(hiz3), .i_pwm1_shutdown_hiz(hiz1),
        .o_pwm_on_default_pins(pwm_dflt), .o_analog_input_13(a13), .o_analog_input_14(a14),
        .o_analog_input_15(a15), .o_comparator2_input_d(), .o_comparator1_input_c());

    board_pins u_board (.i_clock(i_clock), .i_out(pin_out), .i_oe(pin_oe), .i_drive(drv),
        .i_drive_en(drv_en), .o_level(pin));

    // small package copy on the same bus and pins; its port must stay dead
    logic [31:0] prdata_s;
    logic [7:0]  oe_s;
    upper_port_pin_function_mux #(.SMALL_PACKAGE(1)) u_dut_small (.i_clock(i_clock),
        .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata_s), .o_pready(), .o_pslverr(),
        .i_pin_in(pin), .o_pin_out(), .o_pin_oe(oe_s), .i_pport_active(pp_act),
        .i_pport_slave_mode(pp_slave), .i_pport_byte_enable(pp_be), .i_pport_read_strobe(pp_rd),
        .i_pport_write_strobe(pp_wr), .o_pport_read_in(), .o_pport_write_in(),
        .i_pwm3_channel_b(p3b), .i_pwm1_channel_c(p1c), .i_pwm1_channel_b(p1b),
        .i_pwm_chan_en(chan_en), .i_pwm3_shutdown_hiz(hiz3), .i_pwm1_shutdown_hiz(hiz1),
        .o_pwm_on_default_pins(), .o_analog_input_13(), .o_analog_input_14(),
        .o_analog_input_15(), .o_comparator2_input_d(), .o_comparator1_input_c());

    // ============================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            $display("[ERR] %s expected %h seen %h", nm, x, g);
            n_fail++;
        end
    endtask

    // apb transfer: held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge i_clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clock);
        penable <= 1'h1;
        // only the watchdog ends a wait for the slave's answer
        do
        begin
            @(posedge i_clock);
        end
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'h1, a, {24'h0, d}, r, e);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        xfer(1'h0, a, 32'h0, r, e);
        chk(nm, {24'h0, x}, r);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset;
        #1;
        chk("pin_oe", 8'h00, pin_oe);
        chk("analog", 3'h7, {a15, a14, a13});
        chk("pwm_dflt", 1'h1, pwm_dflt);
        rdchk("latch", `UP_OFF_LATCH, 8'h00);
        rdchk("dir", `UP_OFF_DIRECTION, 8'hFF);
        rdchk("shared", `UP_OFF_SHARED, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_plain;
        wr(`UP_OFF_LATCH, 8'h20);
        wr(`UP_OFF_DIRECTION, 8'hDF);
        #1;
        chk("pin_out5", 1'h1, pin_out[5]);
        chk("pin_oe", 8'h20, pin_oe);
        wr(`UP_OFF_WATCHDOG, 8'h10);
        wr(`UP_OFF_SHARED, 8'hFF);
        rdchk("analog_sel", `UP_OFF_SHARED, 8'hFC);
        chk("analog", 3'h0, {a15, a14, a13});
        wr(`UP_OFF_WATCHDOG, 8'h00);
        wr(`UP_OFF_SHARED, 8'h5A);
        rdchk("shared_dflt", `UP_OFF_SHARED, 8'h5A);
        chk("analog", 3'h0, {a15, a14, a13});
        wr(`UP_OFF_DIRECTION, 8'hFF);
        drv <= 8'hA5;
        drv_en <= 8'hFF;
        repeat (3) @(posedge i_clock);
        rdchk("pin_levels", `UP_OFF_PIN_LEVELS, 8'hA5);
        $display("plain port test done");
    endtask

    task automatic t_pport;
        wr(`UP_OFF_MUX_CFG, 8'h02);
        pp_act <= 1'h1;
        pp_be <= 1'h1;
        pp_wr <= 1'h1;
        @(posedge i_clock);
        #1;
        chk("pport_oe", 3'h7, pin_oe[7:5]);
        chk("pport_out", 3'h5, pin_out[7:5]);
        @(posedge i_clock);
        pp_slave <= 1'h1;
        drv <= 8'h40;
        @(posedge i_clock);
        #1;
        chk("slave_oe", 3'h1, pin_oe[7:5]);
        chk("strobe_in", 2'h1, {wr_in, rd_in});
        wr(`UP_OFF_MUX_CFG, 8'h03);
        pp_slave <= 1'h0;
        #1;
        chk("no_pport_oe", 3'h0, pin_oe[7:5]);
        $display("parallel port test done");
    endtask

    task automatic t_pwm;
        wr(`UP_OFF_DIRECTION, 8'h1F);
        chan_en <= 3'h7;
        p3b <= 1'h1;
        p1c <= 1'h1;
        @(posedge i_clock);
        #1;
        chk("pwm_off_out", 3'h1, pin_out[7:5]);
        wr(`UP_OFF_MUX_CFG, 8'h00);
        #1;
        chk("pwm_out", 3'h3, pin_out[7:5]);
        chk("pwm_oe", 3'h7, pin_oe[7:5]);
        chk("pwm_dflt", 1'h0, pwm_dflt);
        @(posedge i_clock);
        hiz3 <= 1'h1;
        @(posedge i_clock);
        #1;
        chk("hiz3_oe", 3'h6, pin_oe[7:5]);
        @(posedge i_clock);
        hiz1 <= 1'h1;
        @(posedge i_clock);
        #1;
        chk("hiz1_oe", 3'h0, pin_oe[7:5]);
        $display("pwm test done");
    endtask

    task automatic t_refuse;
        logic [31:0] r;
        logic        e;
        xfer(1'h0, 8'h20, 32'h0, r, e);
        chk("unmapped_err", 1'h1, e);
        chk("unmapped_rd", 32'h0, r);
        xfer(1'h1, 8'h20, 32'hFF, r, e);
        chk("unmapped_wr_err", 1'h1, e);
        rdchk("latch", `UP_OFF_LATCH, 8'h20);
        wr(`UP_OFF_PIN_LEVELS, 8'h40);
        rdchk("latch", `UP_OFF_LATCH, 8'h40);
        chk("small_latch", 32'h0, prdata_s);
        chk("small_oe", 8'h00, oe_s);
        $display("refusal test done");
    endtask

    // ============================================================
    // main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge i_clock);
        i_resetn <= 1'h1;
        t_reset();
        t_plain();
        t_pport();
        t_pwm();
        t_refuse();
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge i_clock);
        n_fail++;
        complete_run();
    end
endmodule

`default_nettype wire
